/* File: rtl/pms_mgmt_slave.sv */
// serial management slave: frame decoder, read driver, write path, strap latch
//
// Function
// - station makes the management clock, at most 25 MHz; this slave needs each mdc phase to span three system clocks.
// - stopped management clock while idle is harmless; decoding resumes on restart.
// - data line is sampled on the management clock rising edge.
// - line undriven during idle and undriven turnaround bits.
// - only frames whose device address matches our own are acted on.
// - bus address captured from straps at power-up reset, held until next.
// - register address field selects one of 32 sixteen-bit registers directly.
// - frame recognised only on start code 01 after idle high.
// - field order idle, start, opcode, addresses, turnaround, data; read opcode 10.
// - nobody drives the first turnaround bit of a read.
// - on our read: drive zero on second turnaround, 16 data bits, release.
// - data field is read response, or loaded into addressed register on write.
`include "pms_cfg.svh"
module pms_mgmt_slave
  import pms_pkg::*;
(
  // clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   sys_rst_in,
  // management pins
  input  wire logic                   mdc_in,
  input  wire logic                   mdio_in,
  output logic                        mdio_out,
  output logic                        mdio_oe_out,
  // address straps
  input  wire logic [`PMS_ADDR_W-1:0] bus_address_strap_in,
  output logic      [`PMS_ADDR_W-1:0] bus_address_out,
  // write notification
  output logic                        wr_strobe_out,
  output logic      [`PMS_ADDR_W-1:0] wr_addr_out,
  output logic      [`PMS_DATA_W-1:0] wr_data_out
);
  // limitation: each mdc phase must span three system clocks; fast mdc is missed

  // ==========================================================
  // synchronised pins
  logic                   mdc_s;
  logic                   mdio_s;
  logic [`PMS_ADDR_W-1:0] strap_s;

  pms_sync #(.W(2)) u_sync_mgmt (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   ({mdc_in, mdio_in}),
    .sync_out   ({mdc_s, mdio_s})
  );

  pms_sync #(.W(`PMS_ADDR_W)) u_sync_strap (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   (bus_address_strap_in),
    .sync_out   (strap_s)
  );

  pms_reg_if regs ();

  pms_regfile u_regfile (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .regs       (regs)
  );

  // ==========================================================
  // state
  pms_state_type          state_r,    state_nxt;
  logic                   mdc_d_r,    mdc_d_nxt;
  logic                   idle_hi_r,  idle_hi_nxt;
  logic [`PMS_CNT_W-1:0]  cnt_r,      cnt_nxt;
  logic [`PMS_OP_W-1:0]   op_r,       op_nxt;
  logic [9:0]             addr_r,     addr_nxt;
  logic [`PMS_DATA_W-1:0] sh_r,       sh_nxt;
  logic                   rd_r,       rd_nxt;
  logic                   oe_r,       oe_nxt;
  logic                   dout_r,     dout_nxt;
  logic                   wr_r,       wr_nxt;
  logic [`PMS_ADDR_W-1:0] wra_r,      wra_nxt;
  logic [`PMS_DATA_W-1:0] wrd_r,      wrd_nxt;
  logic [`PMS_ADDR_W-1:0] myaddr_r,   myaddr_nxt;
  logic [1:0]             settle_r,   settle_nxt;
  logic                   captured_r, captured_nxt;
  logic                   mdc_rise;
  logic                   mine;

  // rising edge of the sampled management clock; no timeout, so a stopped
  // clock simply freezes the decoder until edges return
  assign mdc_rise = mdc_s & ~mdc_d_r;
  // device address field sits in the upper five bits of addr_r
  assign mine     = (addr_r[9:5] == myaddr_r);

  // register array: address field used directly as the index
  assign regs.rd_addr = addr_r[`PMS_ADDR_W-1:0];
  assign regs.wr_en   = wr_r;
  assign regs.wr_addr = wra_r;
  assign regs.wr_data = wrd_r;

  // ==========================================================
  // strap capture: wait for the synchroniser to fill after release, then
  // latch once; the station stays quiet meanwhile, so no frame is lost
  always_comb begin
    settle_nxt   = settle_r;
    captured_nxt = captured_r;
    myaddr_nxt   = myaddr_r;
    if (!captured_r) begin
      if (settle_r == `PMS_STRAP_SETTLE) begin
        captured_nxt = 1'b1;
        myaddr_nxt   = strap_s;
      end else begin
        settle_nxt = settle_r + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      settle_r   <= 2'h0;
      captured_r <= 1'b0;
      myaddr_r   <= '0;
    end else begin
      settle_r   <= settle_nxt;
      captured_r <= captured_nxt;
      myaddr_r   <= myaddr_nxt;
    end
  end

  // ==========================================================
  // frame decoder; every step happens on a sampled rising edge only
  always_comb begin
    state_nxt   = state_r;
    mdc_d_nxt   = mdc_s;
    idle_hi_nxt = idle_hi_r;
    cnt_nxt     = cnt_r;
    op_nxt      = op_r;
    addr_nxt    = addr_r;
    sh_nxt      = sh_r;
    rd_nxt      = rd_r;
    oe_nxt      = oe_r;
    dout_nxt    = dout_r;
    wr_nxt      = 1'b0;
    wra_nxt     = wra_r;
    wrd_nxt     = wrd_r;
    if (mdc_rise && captured_r) begin
      cnt_nxt = cnt_r + 5'h01;
      case (state_r)
        PMS_S_IDLE: begin
          oe_nxt      = 1'b0;
          idle_hi_nxt = mdio_s;
          if (idle_hi_r && !mdio_s) begin
            state_nxt = PMS_S_START;
          end
        end
        PMS_S_START: begin
          cnt_nxt     = '0;
          idle_hi_nxt = mdio_s;
          state_nxt   = (mdio_s == `PMS_START_LAST) ? PMS_S_OP : PMS_S_IDLE;
        end
        PMS_S_OP: begin
          op_nxt = {op_r[0], mdio_s};
          if (cnt_r == `PMS_OP_LAST) begin
            cnt_nxt   = '0;
            state_nxt = PMS_S_ADDR;
          end
        end
        PMS_S_ADDR: begin
          addr_nxt = {addr_r[8:0], mdio_s};
          if (cnt_r == `PMS_ADDR_LAST) begin
            cnt_nxt = '0;
            rd_nxt  = (op_r == `PMS_OP_READ);
            // a foreign address or unknown opcode is skipped silently
            if (addr_r[8:4] == myaddr_r &&
                (op_r == `PMS_OP_READ || op_r == `PMS_OP_WRITE)) begin
              state_nxt = PMS_S_TA;
            end else begin
              state_nxt = PMS_S_SKIP;
            end
          end
        end
        PMS_S_TA: begin
          // this edge samples the first turnaround bit; we drive only after it
          if (cnt_r == '0) begin
            if (rd_r) begin
              oe_nxt   = 1'b1;
              dout_nxt = `PMS_TA_ZERO;
              sh_nxt   = regs.rd_data;
            end
          end else begin
            cnt_nxt   = '0;
            state_nxt = PMS_S_DATA;
            if (rd_r) begin
              dout_nxt = sh_r[`PMS_DATA_W-1];
              sh_nxt   = {sh_r[`PMS_DATA_W-2:0], 1'b0};
            end
          end
        end
        PMS_S_DATA: begin
          if (rd_r) begin
            dout_nxt = sh_r[`PMS_DATA_W-1];
            sh_nxt   = {sh_r[`PMS_DATA_W-2:0], 1'b0};
            if (cnt_r == `PMS_DATA_LAST) begin
              oe_nxt   = 1'b0;
              dout_nxt = 1'b0;
            end
          end else begin
            oe_nxt = 1'b0;
            sh_nxt = {sh_r[`PMS_DATA_W-2:0], mdio_s};
          end
          if (cnt_r == `PMS_DATA_LAST) begin
            state_nxt   = PMS_S_IDLE;
            idle_hi_nxt = 1'b0;
            if (!rd_r) begin
              wr_nxt  = 1'b1;
              wra_nxt = addr_r[`PMS_ADDR_W-1:0];
              wrd_nxt = {sh_r[`PMS_DATA_W-2:0], mdio_s};
            end
          end
        end
        PMS_S_SKIP: begin
          oe_nxt = 1'b0;
          if (cnt_r == `PMS_SKIP_LAST) begin
            state_nxt   = PMS_S_IDLE;
            idle_hi_nxt = 1'b0;
          end
        end
        default: begin
          state_nxt = PMS_S_IDLE;
          oe_nxt    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_r   <= PMS_S_IDLE;
      mdc_d_r   <= 1'b1;
      idle_hi_r <= 1'b0;
      cnt_r     <= '0;
      op_r      <= '0;
      addr_r    <= '0;
      sh_r      <= '0;
      rd_r      <= 1'b0;
      oe_r      <= 1'b0;
      dout_r    <= 1'b0;
      wr_r      <= 1'b0;
      wra_r     <= '0;
      wrd_r     <= '0;
    end else begin
      state_r   <= state_nxt;
      mdc_d_r   <= mdc_d_nxt;
      idle_hi_r <= idle_hi_nxt;
      cnt_r     <= cnt_nxt;
      op_r      <= op_nxt;
      addr_r    <= addr_nxt;
      sh_r      <= sh_nxt;
      rd_r      <= rd_nxt;
      oe_r      <= oe_nxt;
      dout_r    <= dout_nxt;
      wr_r      <= wr_nxt;
      wra_r     <= wra_nxt;
      wrd_r     <= wrd_nxt;
    end
  end

  // ==========================================================
  // outputs straight from flops; the pad resolves the pulled-up wire
  assign mdio_out        = dout_r;
  assign mdio_oe_out     = oe_r;
  assign bus_address_out = myaddr_r;
  assign wr_strobe_out   = wr_r;
  assign wr_addr_out     = wra_r;
  assign wr_data_out     = wrd_r;

  // ==========================================================
  // helper: management rising edges counted while we drive
  logic [`PMS_CNT_W:0] drv_bits_r;
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      drv_bits_r <= '0;
    end else if (!oe_r) begin
      drv_bits_r <= '0;
    end else if (mdc_rise) begin
      drv_bits_r <= drv_bits_r + 6'h01;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  idle_undriven_a: assert property (
    (state_r == PMS_S_IDLE && $past(state_r) == PMS_S_IDLE) |-> !oe_r)
    else $error("line driven while idle");

  ta_zero_first_a: assert property ($rose(oe_r) |-> !dout_r)
    else $error("second turnaround bit not zero");

  drive_read_only_a: assert property (oe_r |-> rd_r && state_r != PMS_S_SKIP)
    else $error("line driven outside an own read");

  drive_own_addr_a: assert property (oe_r |-> mine)
    else $error("line driven for a foreign address");

  strap_held_a: assert property (
    captured_r && $past(captured_r) |-> $stable(myaddr_r))
    else $error("bus address changed after capture");

  read_length_a: assert property (
    $fell(oe_r) |-> drv_bits_r == 6'h11)
    else $error("read did not drive exactly seventeen bits");

  start_after_idle_a: assert property (
    (state_r == PMS_S_START && $past(state_r) == PMS_S_IDLE) |->
      $past(idle_hi_r) && !$past(mdio_s))
    else $error("start accepted without idle high then zero");

  edge_only_a: assert property (!mdc_rise |=> $stable(sh_r) && $stable(state_r))
    else $error("decoder moved without a clock edge");

  write_strobe_a: assert property (
    wr_r |-> $past(state_r) == PMS_S_DATA && !$past(rd_r) &&
             wra_r == $past(addr_r[`PMS_ADDR_W-1:0]))
    else $error("write strobe without write frame");

  ta1_quiet_a: assert property (
    (state_r == PMS_S_TA && cnt_r == '0) |-> !oe_r)
    else $error("first turnaround bit driven");

  read_seen_c:  cover property ($fell(oe_r));
  write_seen_c: cover property (wr_r);
  skip_seen_c:  cover property (state_r == PMS_S_SKIP && cnt_r == `PMS_SKIP_LAST);
  strap_cap_c:  cover property ($rose(captured_r));
endmodule

/* File: rtl/pms_cfg.svh */
// constants of the management serial slave: field widths, codes, counts
`ifndef PMS_CFG_SVH
`define PMS_CFG_SVH

// ==========================================================
// frame fields
`define PMS_ADDR_W        5
`define PMS_DATA_W        16
`define PMS_REG_COUNT     32
`define PMS_OP_W          2
`define PMS_OP_READ       2'h2
`define PMS_OP_WRITE      2'h1
`define PMS_START_LAST    1'h1
`define PMS_TA_ZERO       1'h0

// ==========================================================
// bit counts, expressed as last index of a 5-bit counter
`define PMS_CNT_W         5
`define PMS_OP_LAST       5'h01
`define PMS_ADDR_LAST     5'h09
`define PMS_TA_LAST       5'h01
`define PMS_DATA_LAST     5'h0f
`define PMS_SKIP_LAST     5'h11

// ==========================================================
// timing
`define PMS_CLK_HZ        10000000
`define PMS_MDC_MAX_HZ    25000000
`define PMS_STRAP_SETTLE  2'h3
`define PMS_REG_RESET     16'h0000

`endif

/* File: rtl/pms_pkg.sv */
// types shared by the management serial slave modules
package pms_pkg;
  // frame decoder states
  typedef enum logic [2:0] {
    PMS_S_IDLE,
    PMS_S_START,
    PMS_S_OP,
    PMS_S_ADDR,
    PMS_S_TA,
    PMS_S_DATA,
    PMS_S_SKIP
  } pms_state_type;
endpackage

/* File: rtl/pms_reg_if.sv */
// register store access between the frame decoder and the register array
`include "pms_cfg.svh"
interface pms_reg_if;
  logic [`PMS_ADDR_W-1:0] rd_addr;
  logic [`PMS_DATA_W-1:0] rd_data;
  logic                   wr_en;
  logic [`PMS_ADDR_W-1:0] wr_addr;
  logic [`PMS_DATA_W-1:0] wr_data;

  modport decoder (output rd_addr, input rd_data, output wr_en, output wr_addr,
                   output wr_data);
  modport store   (input rd_addr, output rd_data, input wr_en, input wr_addr,
                   input wr_data);
endinterface

/* File: rtl/pms_sync.sv */
// two-stage synchroniser for pins entering the system clock domain
module pms_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         sys_rst_in,
  // pin side and synchronised side
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  // ==========================================================
  // sync chain: first stage is read only by the second
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_r   <= '1;
      sync_out <= '1;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

/* File: rtl/pms_regfile.sv */
// 32 x 16-bit register array behind the management frame decoder
`include "pms_cfg.svh"
module pms_regfile (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  // decoder access
  pms_reg_if.store  regs
);
  logic [`PMS_DATA_W-1:0] mem_r [`PMS_REG_COUNT];

  // ==========================================================
  // combinational read, so read data is ready on the same bit edge
  assign regs.rd_data = mem_r[regs.rd_addr];

  // ==========================================================
  // write port: whole 16-bit word loaded at once
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < `PMS_REG_COUNT; i++) begin
        mem_r[i] <= `PMS_REG_RESET;
      end
    end else if (regs.wr_en) begin
      mem_r[regs.wr_addr] <= regs.wr_data;
    end
  end
endmodule

/* File: dv/pms_sta_model.sv */
// station-side model of the management bus: clock maker, data driver and sampler
`include "pms_cfg.svh"
module pms_sta_model (
  // resolved data line
  input  wire logic mdio_in,
  // station pins
  output logic      mdc_out,
  output logic      sta_oe_out,
  output logic      sta_dat_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // idle state: clock parked low, line released to the pull-up
  initial begin
    mdc_out = 1'b0;
    sta_oe_out = 1'b0;
    sta_dat_out = 1'b0;
  end

  // ==========================================================
  // one frame of two idle bits plus 32 frame bits, 800 ns a bit
  // the clock stops again afterwards, so every gap is a stopped-clock idle
  task automatic frame(input logic [1:0] op, input logic [4:0] dev, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [17:0] cap);
    logic [33:0] bits;
    logic        rd;
    rd = (op == `PMS_OP_READ);
    bits = {2'h3, 2'h1, op, dev, ra, 2'h2, wd}; // start 01, fields msb first
    cap = '0;
    for (int i = 33; i >= 0; i--) begin
      // data moves in the low half, well clear of the sampling edge
      sta_oe_out <= (i < 32) && !(rd && i < 18); // idle bits, read turnaround and read data released
      sta_dat_out <= bits[i]; // write turnaround 10 driven here
      #400;
      cap = {cap[16:0], mdio_in}; // sampled at the rising edge
      mdc_out <= 1'b1;
      #400;
      mdc_out <= 1'b0;
    end
    // release, then one more low phase so the slave finishes its bookkeeping
    sta_oe_out <= 1'b0;
    #400;
  endtask
endmodule

/* File: dv/tb_top.sv */
// self-checking testbench of the management serial slave
`include "pms_cfg.svh"
`define CHK_EQ(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // signals
  logic        clk_in;
  logic        sys_rst_in;
  logic        mdc;
  logic        mdio;
  logic        sta_oe;
  logic        sta_dat;
  logic        dut_out;
  logic        dut_oe;
  logic        strobe;
  logic [4:0]  strap;
  logic [4:0]  own;
  logic [4:0]  waddr;
  logic [15:0] wdata;
  logic [17:0] cap;
  int          err_count;
  int          samples_checked;
  int          oe_cycles;
  int          strobe_cnt;

  // wire level: contention shows as unknown, released line pulled high
  assign mdio = (dut_oe && sta_oe) ? 1'bx : dut_oe ? dut_out : sta_oe ? sta_dat : 1'b1;

  pms_mgmt_slave pms_mgmt_slave_i (
    .clk_in               (clk_in),
    .sys_rst_in           (sys_rst_in),
    .mdc_in               (mdc),
    .mdio_in              (mdio),
    .mdio_out             (dut_out),
    .mdio_oe_out          (dut_oe),
    .bus_address_strap_in (strap),
    .bus_address_out      (own),
    .wr_strobe_out        (strobe),
    .wr_addr_out          (waddr),
    .wr_data_out          (wdata)
  );

  pms_sta_model pms_sta_model_i (
    .mdio_in     (mdio),
    .mdc_out     (mdc),
    .sta_oe_out  (sta_oe),
    .sta_dat_out (sta_dat)
  );

  // ==========================================================
  // clock, activity counters, watchdog
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  // counting drive cycles and strobes lets silent frames be judged afterwards
  always @(posedge clk_in) begin
    if (dut_oe === 1'b1) oe_cycles++;
    if (strobe === 1'b1) strobe_cnt++;
  end

  initial begin
    repeat (100000) @(posedge clk_in);
    err_count++;
    report_and_stop();
  end

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ==========================================================
  // helpers
  task automatic do_reset(input logic [4:0] s);
    @(posedge clk_in) sys_rst_in <= 1'b1;
    strap <= s;
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (20) @(posedge clk_in); // quiet bus for 2 us after release
  endtask

  task automatic rd_chk(input logic [4:0] dev, input logic [4:0] ra, input logic [15:0] d);
    pms_sta_model_i.frame(`PMS_OP_READ, dev, ra, 16'h0000, cap);
    `CHK_EQ(cap, {2'h2, d}) // released first, zero second, then data
    `CHK_EQ(dut_oe, 1'b0) // line released after the word
  endtask

  // ==========================================================
  // scenarios
  task automatic t_strap();
    do_reset(5'h0b);
    `CHK_EQ(own, 5'h0b)
    `CHK_EQ(dut_oe, 1'b0)
    @(posedge clk_in) strap <= 5'h14;
    repeat (20) @(posedge clk_in);
    `CHK_EQ(own, 5'h0b) // strap moves after reset are ignored
  endtask

  // boundary addresses 0 and 31 plus a mixed pattern, written then read back
  task automatic t_write_read();
    logic [4:0]  ras [3] = '{5'h00, 5'h1f, 5'h05};
    logic [15:0] ds  [3] = '{16'h8001, 16'h7ffe, 16'ha5c3};
    int          s0;
    foreach (ras[i]) begin
      s0 = strobe_cnt;
      pms_sta_model_i.frame(`PMS_OP_WRITE, 5'h0b, ras[i], ds[i], cap);
      `CHK_EQ(cap, {2'h2, ds[i]}) // slave never drives in a write
      `CHK_EQ(strobe_cnt, s0 + 1)
      `CHK_EQ(waddr, ras[i])
      `CHK_EQ(wdata, ds[i])
    end
    foreach (ras[i]) rd_chk(5'h0b, ras[i], ds[i]);
  endtask

  task automatic t_foreign();
    int o0;
    int s0;
    o0 = oe_cycles;
    s0 = strobe_cnt;
    pms_sta_model_i.frame(`PMS_OP_READ, 5'h0c, 5'h05, 16'h0000, cap);
    `CHK_EQ(cap, 18'h3ffff) // nobody answers, line stays high
    pms_sta_model_i.frame(`PMS_OP_WRITE, 5'h1b, 5'h05, 16'h1234, cap);
    `CHK_EQ(oe_cycles, o0)
    `CHK_EQ(strobe_cnt, s0)
    rd_chk(5'h0b, 5'h05, 16'ha5c3);
  endtask

  // the two opcodes that are neither read nor write
  task automatic t_bad_op();
    logic [1:0] ops [2] = '{2'h0, 2'h3};
    int         o0;
    int         s0;
    foreach (ops[i]) begin
      o0 = oe_cycles;
      s0 = strobe_cnt;
      pms_sta_model_i.frame(ops[i], 5'h0b, 5'h05, 16'h5555, cap);
      `CHK_EQ(cap, {2'h2, 16'h5555}) // station alone on the line
      `CHK_EQ(oe_cycles, o0)
      `CHK_EQ(strobe_cnt, s0)
    end
    rd_chk(5'h0b, 5'h05, 16'ha5c3);
  endtask

  task automatic t_clock_stop();
    #20000; // management clock parked for a long while
    rd_chk(5'h0b, 5'h1f, 16'h7ffe);
  endtask

  task automatic t_rereset();
    int o0;
    do_reset(5'h1f);
    `CHK_EQ(own, 5'h1f) // address recaptured on the new reset
    rd_chk(5'h1f, 5'h05, 16'h0000);
    o0 = oe_cycles;
    pms_sta_model_i.frame(`PMS_OP_READ, 5'h0b, 5'h05, 16'h0000, cap);
    `CHK_EQ(cap, 18'h3ffff) // line stays pulled high
    `CHK_EQ(oe_cycles, o0) // old address no longer answers
  endtask

  // ==========================================================
  // main sequence
  initial begin
    sys_rst_in = 1'b1;
    strap = 5'h00;
    err_count = 0;
    samples_checked = 0;
    oe_cycles = 0;
    strobe_cnt = 0;
    t_strap();
    t_write_read();
    t_foreign();
    t_bad_op();
    t_clock_stop();
    t_rereset();
    report_and_stop();
  end
endmodule
